// file: rtl/portrait_rotation_refresh.sv
`timescale 1ns/100ps

module portrait_rotation_refresh
   import rotation_refresh_pkg::*;
#(
   parameter int HACT = 320,
   parameter int VACT = 240,
   parameter int BPP  = 4
)
(
   // clock and reset
   input  wire logic              mclk,
   input  wire logic              rst,
   // ahb-lite slave
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output      logic [31:0]       hrdata,
   output      logic              hreadyout,
   output      logic              hresp,
   // panel refresh
   output      logic              pixelStrobe,
   output      logic              lineStart,
   output      logic              frameStart,
   output      logic [ADDR_W-1:0] displayAddr,
   output      logic              portraitActive,
   output      logic              memClkFull
);

   localparam int LAND_STRIDE = HACT * BPP / 8;

   if (HACT < 1 || HACT >= (1 << CNT_W) - 256 || VACT < 1 || VACT >= (1 << CNT_W) - 256)
   begin
      $error("panel size out of counter range");
   end
   if (BPP != 1 && BPP != 2 && BPP != 4 && BPP != 8)
   begin
      $error("bits per pixel must be 1, 2, 4 or 8");
   end

   state_t             s;
   state_t             n;
   logic               busAcc;
   logic               cpuBusy;
   mode_t              mode;
   logic [15:0]        startWord;
   logic [15:0]        startEff;
   logic [1:0]         pixSel;
   logic [2:0]         divShift;
   logic [DIV_W-1:0]   pixDiv;
   logic [CNT_W-1:0]   hTotal;
   logic [CNT_W-1:0]   vTotal;
   logic [ADDR_W-1:0]  vByte;
   logic [ADDR_W-1:0]  portAddr;
   logic [ADDR_W-1:0]  landAddr;
   logic [7:0]         accIdx;
   logic [31:0]        rdMux;

   assign busAcc    = hsel && hready && htrans[1];
   assign cpuBusy   = busAcc || s.wrPend;
   assign accIdx    = (haddr[31:10] == 22'h00_0000) ? haddr[9:2] : IDX_UNMAPPED;
   assign startWord = {s.regs.startHi, s.regs.startLo};
   assign pixSel    = s.regs.rotCtl[1:0];

   // mode decode: enable bit over scheme bit
   always_comb
   begin
      if (!s.regs.rotCtl[ROT_ENABLE_BIT])
         mode = MODE_LANDSCAPE;
      else if (s.regs.rotCtl[ROT_ALT_BIT])
         mode = MODE_ALTERNATE;
      else
         mode = MODE_DEFAULT;
   end

   // default scheme: stride is one bit, clearing it rounds to even lines
   assign startEff = (mode == MODE_DEFAULT) ?
                     (startWord & ~{8'h00, s.regs.stride}) :
                     startWord;

   // pixel divider: input divide, then select bits, then base
   always_comb
   begin
      divShift = {2'b00, s.regs.clkCfg[CLK_DIV_BIT]};
      if (mode != MODE_LANDSCAPE)
         divShift = 3'(divShift + {1'b0, pixSel});
      if (mode == MODE_ALTERNATE)
         pixDiv = DIV_W'(ALT_BASE << divShift);
      else
         pixDiv = DIV_W'(STD_BASE << divShift);
   end

   assign hTotal = CNT_W'(HACT + int'(s.regs.hBlank));
   assign vTotal = CNT_W'(VACT + int'(s.regs.vBlank));

   // panel line v scans portrait column from the right edge downward
   assign vByte    = ADDR_W'((int'(s.vCount) * BPP) >> 3);
   assign portAddr = ADDR_W'({1'b0, startEff}
                     + ADDR_W'(int'(s.hCount) * int'(s.regs.stride))
                     - vByte);
   assign landAddr = ADDR_W'({startWord, 1'b0}
                     + ADDR_W'(int'(s.vCount) * LAND_STRIDE)
                     + ADDR_W'((int'(s.hCount) * BPP) >> 3));

   always_comb
   begin
      rdMux = WORD_ZERO;
      unique case (accIdx)
         IDX_CLK_CFG:  rdMux[7:0] = s.regs.clkCfg;
         IDX_HBLANK:   rdMux[7:0] = s.regs.hBlank;
         IDX_VBLANK:   rdMux[7:0] = s.regs.vBlank;
         IDX_START_LO: rdMux[7:0] = s.regs.startLo;
         IDX_START_HI: rdMux[7:0] = s.regs.startHi;
         IDX_ROT_CTL:  rdMux[7:0] = s.regs.rotCtl;
         IDX_STRIDE:   rdMux[7:0] = s.regs.stride;
         IDX_STATUS:   rdMux[15:0] = {5'h00, s.vCount};
         default:      rdMux = WORD_ZERO;
      endcase
      if (accIdx == IDX_STATUS)
         rdMux[23:16] = {pixDiv, mode};
   end

   always_comb
   begin
      n          = s;
      n.pixStb   = 1'b0;
      n.lineStb  = 1'b0;
      n.frameStb = 1'b0;
      // data phase of a write; memory itself is never touched here
      if (s.wrPend)
      begin
         unique case (s.wrIdx)
            IDX_CLK_CFG:  n.regs.clkCfg  = hwdata[7:0] & CLK_CFG_MASK;
            IDX_HBLANK:   n.regs.hBlank  = hwdata[7:0];
            IDX_VBLANK:   n.regs.vBlank  = hwdata[7:0];
            IDX_START_LO: n.regs.startLo = hwdata[7:0];
            IDX_START_HI: n.regs.startHi = hwdata[7:0];
            IDX_ROT_CTL:  n.regs.rotCtl  = hwdata[7:0] & ROT_CTL_MASK;
            IDX_STRIDE:   n.regs.stride  = hwdata[7:0];
            default:      n.regs = s.regs;
         endcase
      end
      n.wrPend = busAcc && hwrite;
      n.wrIdx  = accIdx;
      if (busAcc && !hwrite)
         n.rdata = rdMux;
      // pixel rate divider, recovers if divisor shrinks
      if (s.divCnt >= pixDiv - DIV_W'(1))
      begin
         n.divCnt = '0;
         n.pixStb = 1'b1;
      end
      else
         n.divCnt = DIV_W'(s.divCnt + DIV_W'(1));
      // one screen region only, no second start address
      if (n.pixStb)
      begin
         n.dispAddr = (mode == MODE_LANDSCAPE) ? landAddr : portAddr;
         n.lineStb  = (s.hCount == '0);
         n.frameStb = (s.hCount == '0) && (s.vCount == '0);
         if (s.hCount >= hTotal - CNT_W'(1))
         begin
            n.hCount = '0;
            if (s.vCount >= vTotal - CNT_W'(1))
               n.vCount = '0;
            else
               n.vCount = CNT_W'(s.vCount + CNT_W'(1));
         end
         else
            n.hCount = CNT_W'(s.hCount + CNT_W'(1));
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         s                <= '0;
         s.regs.clkCfg    <= REG_RESET;
         s.regs.rotCtl    <= REG_RESET;
         s.wrIdx          <= IDX_UNMAPPED;
      end
      else
         s <= n;
   end

   assign hrdata         = s.rdata;
   assign hreadyout      = 1'b1;
   assign hresp          = HRESP_OKAY;
   assign pixelStrobe    = s.pixStb;
   assign lineStart      = s.lineStb;
   assign frameStart     = s.frameStb;
   assign displayAddr    = s.dispAddr;
   assign portraitActive = (mode != MODE_LANDSCAPE);
   // default scheme runs memory at half rate unless a cpu access boosts it while ROT_MCLK_BIT is set
   assign memClkFull     = (mode != MODE_DEFAULT) ||
                           (s.regs.rotCtl[ROT_MCLK_BIT] && cpuBusy);

   // pixel strobes counted since the last frame start
   logic [21:0] framePix;
   logic        frameSeen;

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         framePix  <= '0;
         frameSeen <= 1'b0;
      end
      else
      begin
         if (s.frameStb)
            framePix <= 22'h00_0001;
         else if (s.pixStb)
            framePix <= 22'(framePix + 22'h00_0001);
         // a blank period write spoils the frame being counted
         if (s.wrPend && (s.wrIdx == IDX_HBLANK || s.wrIdx == IDX_VBLANK))
            frameSeen <= 1'b0;
         else if (s.frameStb)
            frameSeen <= 1'b1;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   sequence rot_write_addr;
      busAcc && hwrite && accIdx == IDX_ROT_CTL;
   endsequence

   sequence rot_write_data;
      ##1 s.wrPend;
   endsequence

   a_rot_write_takes: assert property (rot_write_addr ##0 rot_write_data |=>
      s.regs.rotCtl == ($past(hwdata[7:0]) & ROT_CTL_MASK))
      else $error("rotation control write not stored");

   a_mode_decode: assert property ((s.regs.rotCtl == ROT_DEFAULT_EN |-> mode == MODE_DEFAULT)
      and (s.regs.rotCtl == ROT_ALT_EN |-> mode == MODE_ALTERNATE))
      else $error("rotation mode decode wrong");

   sequence alt_plain;
      mode == MODE_ALTERNATE && pixSel == 2'b00 && !s.regs.clkCfg[CLK_DIV_BIT];
   endsequence

   a_alt_half_rate: assert property ((alt_plain ##0 s.pixStb) ##1 alt_plain |->
      !s.pixStb ##1 s.pixStb)
      else $error("alternate pixel clock not half rate");

   a_default_full_rate: assert property (mode == MODE_DEFAULT && pixSel == 2'b00
      && !s.regs.clkCfg[CLK_DIV_BIT] && $stable(s.regs.rotCtl) |-> n.pixStb)
      else $error("default pixel clock not at input rate");

   a_even_pan: assert property (s.frameStb && mode == MODE_DEFAULT && $onehot(s.regs.stride)
      && $stable(startWord) && $stable(s.regs.stride) && $stable(mode) |->
      (s.dispAddr[7:0] & s.regs.stride) == 8'h00)
      else $error("default scheme pan not even");

   a_single_pan: assert property (s.frameStb && mode == MODE_ALTERNATE
      && $stable(startWord) && $stable(mode) |-> s.dispAddr == {1'b0, startWord})
      else $error("alternate scheme pan not single line");

   a_origin_addr: assert property (s.frameStb && mode != MODE_LANDSCAPE
      && $stable(startEff) && $stable(mode) |-> s.dispAddr == {1'b0, startEff})
      else $error("frame does not start at start offset");

   a_landscape_ignore: assert property (s.frameStb && mode == MODE_LANDSCAPE
      && $stable(startWord) && $stable(mode) |-> s.dispAddr == {startWord, 1'b0})
      else $error("landscape start not word offset");

   a_memclk_boost: assert property (mode == MODE_DEFAULT |->
      (memClkFull == (s.regs.rotCtl[ROT_MCLK_BIT] && cpuBusy)))
      else $error("memory clock boost wrong");

   a_frame_period: assert property (s.frameStb && frameSeen && $stable(hTotal)
      && $stable(vTotal) && $past(s.frameStb) == 1'b0 |->
      framePix == 22'(int'(hTotal) * int'(vTotal)))
      else $error("frame period not total area");

endmodule

// file: rtl/rotation_refresh_pkg.sv
package rotation_refresh_pkg;

   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_CLK_CFG   = 8'h02;
   localparam logic [7:0] IDX_HBLANK    = 8'h08;
   localparam logic [7:0] IDX_VBLANK    = 8'h0A;
   localparam logic [7:0] IDX_START_LO  = 8'h0C;
   localparam logic [7:0] IDX_START_HI  = 8'h0D;
   localparam logic [7:0] IDX_ROT_CTL   = 8'h1B;
   localparam logic [7:0] IDX_STRIDE    = 8'h1C;
   localparam logic [7:0] IDX_STATUS    = 8'h1E;
   localparam logic [7:0] IDX_UNMAPPED  = 8'hFF;

   // field positions and writable masks
   localparam int         ROT_ENABLE_BIT = 7;
   localparam int         ROT_ALT_BIT    = 6;
   localparam int         ROT_MCLK_BIT   = 2;
   localparam int         CLK_DIV_BIT    = 4;
   localparam logic [7:0] ROT_CTL_MASK   = 8'hC7;
   localparam logic [7:0] CLK_CFG_MASK   = 8'h10;
   localparam logic [7:0] ROT_DEFAULT_EN = 8'h80;
   localparam logic [7:0] ROT_ALT_EN     = 8'hC0;
   localparam logic [7:0] REG_RESET      = 8'h00;

   // bus constants
   localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
   localparam logic        HRESP_OKAY    = 1'h0;
   localparam logic [31:0] WORD_ZERO     = 32'h0000_0000;

   // widths and timing
   localparam int         ADDR_W   = 17;
   localparam int         CNT_W    = 11;
   localparam int         DIV_W    = 6;
   localparam logic [5:0] ALT_BASE = 6'h02;
   localparam logic [5:0] STD_BASE = 6'h01;

   typedef enum logic [1:0] {
      MODE_LANDSCAPE = 2'b00,
      MODE_DEFAULT   = 2'b01,
      MODE_ALTERNATE = 2'b11
   } mode_t;

   typedef struct packed {
      logic [7:0] clkCfg;
      logic [7:0] hBlank;
      logic [7:0] vBlank;
      logic [7:0] startLo;
      logic [7:0] startHi;
      logic [7:0] rotCtl;
      logic [7:0] stride;
   } regs_t;

   typedef struct packed {
      regs_t              regs;
      logic               wrPend;
      logic [7:0]         wrIdx;
      logic [31:0]        rdata;
      logic [DIV_W-1:0]   divCnt;
      logic [CNT_W-1:0]   hCount;
      logic [CNT_W-1:0]   vCount;
      logic [ADDR_W-1:0]  dispAddr;
      logic               pixStb;
      logic               lineStb;
      logic               frameStb;
   } state_t;

endpackage

// file: tb/panel_model.sv
`timescale 1ns/100ps
module panel_model
   import rotation_refresh_pkg::*;
(
   // clock and reset
   input  wire logic              mclk,
   input  wire logic              rst,
   // refresh stream
   input  wire logic              pixelStrobe,
   input  wire logic              lineStart,
   input  wire logic              frameStart,
   input  wire logic [ADDR_W-1:0] displayAddr,
   // what the panel saw
   output      logic [7:0]        pixGap,
   output      logic [7:0]        lineLen,
   output      logic [15:0]       frameLen,
   output      logic [ADDR_W-1:0] addrAt [0:255]
);
   logic [7:0]  gapCnt;
   logic [7:0]  col;
   logic [7:0]  row;
   logic [15:0] pixCnt;
   logic [3:0]  nc;
   logic [3:0]  nr;

   // position of the pixel now strobed
   assign nc = lineStart ? 4'h0 : col[3:0] + 4'h1;
   assign nr = frameStart ? 4'h0 : (lineStart ? row[3:0] + 4'h1 : row[3:0]);

   always @(posedge mclk)
   begin
      if (rst)
      begin
         gapCnt <= 8'h00;
         pixGap <= 8'h00;
         lineLen <= 8'h00;
         frameLen <= 16'h0000;
         pixCnt <= 16'h0000;
         col <= 8'h00;
         row <= 8'h00;
      end
      else if (pixelStrobe)
      begin
         pixGap <= gapCnt + 8'h01;
         gapCnt <= 8'h00;
         pixCnt <= frameStart ? 16'h0001 : pixCnt + 16'h0001;
         if (frameStart)
            frameLen <= pixCnt;
         if (lineStart)
            lineLen <= col + 8'h01;
         col <= {4'h0, nc};
         row <= {4'h0, nr};
         addrAt[{nr, nc}] <= displayAddr;
      end
      else
         gapCnt <= gapCnt + 8'h01;
   end
endmodule

// file: tb/testbench.sv
`timescale 1ns/100ps
module testbench
   import rotation_refresh_pkg::*;
;
   typedef struct packed {
      logic [7:0] rot, clk, stLo, strd, hb, vb, gap;
   } cfg_t;
   localparam int HA = 8;
   localparam int VA = 4;
   localparam int BP = 4;
   // rotation, clock config, start, stride, blanks, pixel gap
   localparam cfg_t CFGS [0:5] = '{
      '{8'h03, 8'h10, 8'h05, 8'h33, 8'h00, 8'h00, 8'h02}, // landscape
      '{8'h80, 8'h00, 8'h01, 8'h02, 8'h02, 8'h01, 8'h01}, // default
      '{8'h84, 8'h00, 8'h03, 8'h02, 8'h00, 8'h00, 8'h01}, // memory clock boost
      '{8'hC0, 8'h00, 8'h03, 8'h02, 8'h00, 8'h00, 8'h02}, // alternate
      '{8'hC1, 8'h00, 8'h01, 8'h02, 8'h00, 8'h00, 8'h04}, // pixel select
      '{8'h82, 8'h10, 8'h01, 8'h02, 8'h00, 8'h00, 8'h08}}; // both dividers
   localparam logic [7:0] IDX [0:7] = '{IDX_CLK_CFG, IDX_HBLANK, IDX_VBLANK,
      IDX_START_LO, IDX_START_HI, IDX_ROT_CTL, IDX_STRIDE, IDX_UNMAPPED};
   localparam logic [7:0] MSK [0:7] = '{CLK_CFG_MASK, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
      ROT_CTL_MASK, 8'hFF, 8'h00};

   logic              mclk, rst, hsel, hwrite, hreadyout, hresp, memSeen;
   logic              pixelStrobe, lineStart, frameStart, portraitActive, memClkFull;
   logic [31:0]       haddr, hwdata, hrdata, rd;
   logic [1:0]        htrans;
   logic [2:0]        hsize;
   logic [ADDR_W-1:0] displayAddr;
   logic [ADDR_W-1:0] addrAt [0:255];
   logic [7:0]        pixGap, lineLen;
   logic [15:0]       frameLen;
   cfg_t              c;
   int                errCount, totalChecks, i, h, v;

   portrait_rotation_refresh #(.HACT(HA), .VACT(VA), .BPP(BP)) u_dut (
      .mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .pixelStrobe(pixelStrobe), .lineStart(lineStart), .frameStart(frameStart),
      .displayAddr(displayAddr), .portraitActive(portraitActive),
      .memClkFull(memClkFull));

   panel_model u_panel (
      .mclk(mclk), .rst(rst), .pixelStrobe(pixelStrobe), .lineStart(lineStart),
      .frameStart(frameStart), .displayAddr(displayAddr), .pixGap(pixGap),
      .lineLen(lineLen), .frameLen(frameLen), .addrAt(addrAt));

   initial mclk = 1'b0;
   always #25 mclk = ~mclk;

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      totalChecks++;
      if (got !== exp)
      begin
         errCount++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   // one single transfer; memory clock level sampled in the data phase
   task automatic busCycle(input logic [7:0] idx, input logic wr, input logic [7:0] val);
      @(posedge mclk);
      haddr <= {22'h000000, idx, 2'b00};
      htrans <= HTRANS_NONSEQ;
      hwrite <= wr;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= {24'h000000, val};
      @(negedge mclk);
      memSeen = memClkFull;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task automatic waitFrames(input int n);
      repeat (n)
         do @(posedge mclk); while (frameStart !== 1'b1);
      @(negedge mclk);
   endtask

   function automatic logic [31:0] expAddr(input cfg_t k, input int x, input int y);
      logic [31:0] s;
      if (!k.rot[ROT_ENABLE_BIT])
         return 32'(k.stLo) * 32'h2 + 32'(y * HA * BP / 8 + x * BP / 8);
      // default scheme keeps only even line counts of the start
      s = k.rot[ROT_ALT_BIT] ? 32'(k.stLo) :
          32'((int'(k.stLo) / int'(k.strd)) / 2 * 2 * int'(k.strd) + int'(k.stLo) % int'(k.strd));
      return s + 32'(x) * 32'(k.strd) - 32'(y * BP / 8);
   endfunction

   task automatic printVerdict;
      $display("checks %0d errors %0d", totalChecks, errCount);
      if (errCount == 0 && totalChecks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial
   begin
      repeat (40000) @(posedge mclk);
      errCount++;
      $display("[FAIL] watchdog expected finish seen timeout");
      printVerdict;
   end

   initial
   begin
      rst = 1'b1;
      hsel = 1'b1;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      errCount = 0;
      totalChecks = 0;
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      check("portrait after reset", 32'h0, 32'(portraitActive));
      for (i = 0; i < 8; i++)
      begin
         busCycle(IDX[i], 1'b0, 8'h00);
         check("reset value", 32'h0, rd);
         busCycle(IDX[i], 1'b1, 8'hFF);
         busCycle(IDX[i], 1'b0, 8'h00);
         check("written value", 32'(MSK[i]), rd);
      end
      check("response", 32'(HRESP_OKAY), 32'(hresp));
      for (i = 0; i < 6; i++)
      begin
         c = CFGS[i];
         busCycle(IDX_CLK_CFG, 1'b1, c.clk);
         busCycle(IDX_HBLANK, 1'b1, c.hb);
         busCycle(IDX_VBLANK, 1'b1, c.vb);
         busCycle(IDX_START_LO, 1'b1, c.stLo);
         busCycle(IDX_START_HI, 1'b1, 8'h00);
         busCycle(IDX_STRIDE, 1'b1, c.strd);
         busCycle(IDX_ROT_CTL, 1'b1, c.rot);
         waitFrames(2);
         check("pixel gap", 32'(c.gap), 32'(pixGap));
         check("frame length", 32'((HA + c.hb) * (VA + c.vb)), 32'(frameLen));
         check("line length", 32'(HA + c.hb), 32'(lineLen));
         check("portrait flag", 32'(c.rot[7]), 32'(portraitActive));
         check("memory clock idle", 32'(!(c.rot[7] && !c.rot[6])), 32'(memClkFull));
         for (v = 0; v < VA; v++)
            for (h = 0; h < HA; h++)
               check("pixel address", expAddr(c, h, v), 32'(addrAt[v*16+h]));
         if (c.rot[7] && c.stLo == c.strd - 8'h01)
            check("origin byte", 32'h0, 32'(addrAt[(VA-1)*16]));
         busCycle(IDX_STATUS, 1'b0, 8'h00);
         check("status mode", 32'({c.rot[7] & c.rot[6], c.rot[7]}), 32'(rd[17:16]));
         check("status divisor", 32'(c.gap), 32'(rd[23:18]));
         busCycle(IDX_HBLANK, 1'b1, c.hb);
         check("memory clock busy", 32'(!(c.rot[7] && !c.rot[6]) || c.rot[2]), 32'(memSeen));
      end
      printVerdict;
   end
endmodule
